// ===== hdl/axh_pkg.sv
// Shared constants and burst arithmetic for the AXI memory slave
// Protocol rules this block is built on
// - A beat moves only when valid meets ready
// - Valid and payload hold until the handshake
// - ARREADY may come before or after ARVALID
// - Read data only after address handshake
// - RVALID never waits for RREADY
// - AWREADY and WREADY may wait on valids
// - AXI3 response only after the WLAST beat
// - AXI4 response after address and WLAST beat
// - BVALID never waits for BREADY
// - AXI3 response also waits for write address
// - Slave generates every address after the first
// - AXI3 length is low four bits plus one
// - AXI4 INCR up to 256, others 16
// - No side ends a burst early
// - Long AXI4 INCR bursts may be split
// - Beat bytes are two to the size field
// - Narrow beats use lanes from their address
// - Burst field: fixed, incr, wrap, reserved
// - Wrap returns to boundary after total size
package axh_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int LANE_W = $clog2(STRB_W);
    localparam int LEN_W = 8;
    localparam int SIZE_W = 3;
    localparam int BURST_W = 2;
    localparam int PAGE_W = 12;  // 4KB page
    localparam int MEM_WORDS = 256;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BURST_FIXED = 2'h0;
    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] BURST_WRAP = 2'h2;
    localparam logic [LEN_W-1:0] SHORT_LEN_MASK = 8'h0f;
    localparam logic [LEN_W-1:0] LEN_ONE = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 32'h1;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0;

    // Beats minus one; AXI3 and non-INCR bursts see only four bits
    function automatic logic [LEN_W-1:0] beats_m1(
        input logic axi4,
        input logic [BURST_W-1:0] burst,
        input logic [LEN_W-1:0] len
    );
        if (axi4 && burst == BURST_INCR) begin
            return len;
        end
        return len & SHORT_LEN_MASK;
    endfunction

    // Bytes per beat
    function automatic logic [ADDR_W-1:0] size_bytes(
        input logic [SIZE_W-1:0] size
    );
        return ADDR_ONE << size;
    endfunction

    // Address of the beat after addr
    function automatic logic [ADDR_W-1:0] next_addr(
        input logic [ADDR_W-1:0] addr,
        input logic [SIZE_W-1:0] size,
        input logic [BURST_W-1:0] burst,
        input logic [LEN_W-1:0] len_m1
    );
        logic [ADDR_W-1:0] step;
        logic [ADDR_W-1:0] inc;
        logic [ADDR_W-1:0] mask;
        step = size_bytes(size);
        // Later INCR and WRAP beats are aligned even if the first was not
        inc = (addr & ~(step - ADDR_ONE)) + step;
        mask = step * (ADDR_W'(len_m1) + ADDR_ONE) - ADDR_ONE;
        case (burst)
            BURST_FIXED: return addr;
            // Reaching boundary plus span folds back to boundary
            BURST_WRAP: return (addr & ~mask) | (inc & mask);
            // Page bits held: a legal burst never leaves its page
            default: return {addr[ADDR_W-1:PAGE_W], inc[PAGE_W-1:0]};
        endcase
    endfunction

    // Byte lanes a beat at addr may touch
    function automatic logic [STRB_W-1:0] lane_mask(
        input logic [ADDR_W-1:0] addr,
        input logic [SIZE_W-1:0] size
    );
        logic [STRB_W-1:0] lanes;
        int nbytes;
        int low;
        int alo;
        lanes = '0;
        nbytes = 1 << size;
        low = int'(addr[LANE_W-1:0]);
        alo = (low / nbytes) * nbytes;
        for (int i = 0; i < STRB_W; i++) begin
            lanes[i] = (i >= low) && (i < alo + nbytes);
        end
        return lanes;
    endfunction
endpackage

// ===== hdl/axh_fifo.sv
// Two-entry buffer on the read data path
`timescale 1ns/1ps
module axh_fifo #(
    parameter int W = 33,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [W-1:0] mem_reg [DEPTH];  // Storage, flops
    logic [W-1:0] mem_next [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic push;
    logic pop;

    // Honest full and empty from the occupancy count
    assign in_ready = (count_reg != CNT_W'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign count = count_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next pointers, storage and count
    always_comb begin
        mem_next = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ?
                '0 : wr_ptr_reg + PTR_W'(1);
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ?
                '0 : rd_ptr_reg + PTR_W'(1);
        end
        case ({push, pop})
            2'h2: count_next = count_reg + CNT_W'(1);
            2'h1: count_next = count_reg - CNT_W'(1);
            default: count_next = count_reg;
        endcase
    end

    // Register; storage cleared so outputs are defined
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mem_reg <= '{default: '0};
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end
endmodule

// ===== hdl/axh_mem.sv
// Word memory with byte-lane writes and registered read
`timescale 1ns/1ps
module axh_mem #(
    parameter int WORDS = 256,
    parameter int W = 32
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [$clog2(WORDS)-1:0] wr_idx,
    input wire logic [W/8-1:0] wr_be,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [$clog2(WORDS)-1:0] rd_idx,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] ram [WORDS];  // Array, no reset
    logic [W-1:0] rd_data_reg, rd_data_next;

    // Read data held until the next read
    always_comb begin
        rd_data_next = rd_en ? ram[rd_idx] : rd_data_reg;
    end

    // A same-cycle write and read of one word returns the old word
    always_ff @(posedge clk_sys) begin
        for (int b = 0; b < W / 8; b++) begin
            if (wr_en && wr_be[b]) begin
                ram[wr_idx][8*b +: 8] <= wr_data[8*b +: 8];
            end
        end
        if (reset) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
endmodule

// ===== hdl/axh_slave.sv
// AXI memory slave: channel handshakes and burst address generation
`timescale 1ns/1ps
module axh_slave #(
    parameter int MEM_WORDS = axh_pkg::MEM_WORDS,
    parameter int BUF_DEPTH = axh_pkg::BUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic axi4_mode,
    input wire logic awvalid,
    output logic awready,
    input wire logic [axh_pkg::ADDR_W-1:0] awaddr,
    input wire logic [axh_pkg::LEN_W-1:0] awlen,
    input wire logic [axh_pkg::SIZE_W-1:0] awsize,
    input wire logic [axh_pkg::BURST_W-1:0] awburst,
    input wire logic wvalid,
    output logic wready,
    input wire logic [axh_pkg::DATA_W-1:0] wdata,
    input wire logic [axh_pkg::STRB_W-1:0] wstrb,
    input wire logic wlast,
    output logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    output logic arready,
    input wire logic [axh_pkg::ADDR_W-1:0] araddr,
    input wire logic [axh_pkg::LEN_W-1:0] arlen,
    input wire logic [axh_pkg::SIZE_W-1:0] arsize,
    input wire logic [axh_pkg::BURST_W-1:0] arburst,
    output logic rvalid,
    input wire logic rready,
    output logic [axh_pkg::DATA_W-1:0] rdata,
    output logic rlast
);
    localparam int IDX_W = $clog2(MEM_WORDS);
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam int BUF_W = axh_pkg::DATA_W + 1;
    localparam int AW = axh_pkg::ADDR_W;
    localparam int LW = axh_pkg::LEN_W;

    // Memory word index of a byte address
    function automatic logic [IDX_W-1:0] word_idx(
        input logic [AW-1:0] a
    );
        return a[axh_pkg::LANE_W +: IDX_W];
    endfunction

    typedef enum logic {RD_IDLE, RD_BURST} axh_rd_t;
    typedef enum logic [1:0] {WR_IDLE, WR_DATA, WR_RESP} axh_wr_t;

    // Read side state
    axh_rd_t rd_state_reg, rd_state_next;
    logic [AW-1:0] rd_addr_reg, rd_addr_next;  // Beat address
    logic [2:0] rd_size_reg, rd_size_next;
    logic [1:0] rd_burst_reg, rd_burst_next;
    logic [LW-1:0] rd_len_reg, rd_len_next;    // Beats minus one
    logic [LW-1:0] rd_left_reg, rd_left_next;  // Issues still owed minus one
    logic rd_infl_reg, rd_infl_next;           // Memory read in flight
    logic rd_infl_last_reg, rd_infl_last_next;

    // Write side state
    axh_wr_t wr_state_reg, wr_state_next;
    logic [AW-1:0] wr_addr_reg, wr_addr_next;
    logic [2:0] wr_size_reg, wr_size_next;
    logic [1:0] wr_burst_reg, wr_burst_next;
    logic [LW-1:0] wr_len_reg, wr_len_next;

    // Handshakes and glue
    logic ar_hs;
    logic aw_hs;
    logic w_hs;
    logic r_hs;
    logic rd_issue;
    logic [CNT_W:0] buf_used;    // Buffered plus in flight
    logic [CNT_W-1:0] buf_count;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [BUF_W-1:0] buf_out;
    logic [axh_pkg::DATA_W-1:0] mem_rdata;
    logic [axh_pkg::STRB_W-1:0] mem_be;

    // Ready outputs come from state only, never from a valid
    assign arready = (rd_state_reg == RD_IDLE);
    assign awready = (wr_state_reg == WR_IDLE);
    // Data waits for its address so the response can follow both
    assign wready = (wr_state_reg == WR_DATA);
    assign bvalid = (wr_state_reg == WR_RESP);

    // A transfer counts only where valid and ready meet
    assign ar_hs = arvalid && arready;
    assign aw_hs = awvalid && awready;
    assign w_hs = wvalid && wready;
    assign r_hs = rvalid && rready;

    // Credit: never launch a read the buffer could not hold
    assign buf_used = {1'b0, buf_count} + (CNT_W + 1)'(rd_infl_reg);
    // Issue ignores rready; only buffer space stalls it
    assign rd_issue = (rd_state_reg == RD_BURST) && buf_in_ready &&
        (buf_used < (CNT_W + 1)'(BUF_DEPTH));

    // Narrow write beats touch only their own lanes
    assign mem_be = wstrb &
        axh_pkg::lane_mask(wr_addr_reg, wr_size_reg);

    // Read burst sequencing
    always_comb begin
        rd_state_next = rd_state_reg;
        rd_addr_next = rd_addr_reg;
        rd_size_next = rd_size_reg;
        rd_burst_next = rd_burst_reg;
        rd_len_next = rd_len_reg;
        rd_left_next = rd_left_reg;
        rd_infl_next = rd_issue;
        rd_infl_last_next = rd_issue && (rd_left_reg == '0);
        case (rd_state_reg)
            RD_IDLE: begin
                // A split piece of a long burst is just one more burst
                if (ar_hs) begin
                    rd_state_next = RD_BURST;
                    rd_addr_next = araddr;
                    rd_size_next = arsize;
                    rd_burst_next = arburst;
                    rd_len_next = axh_pkg::beats_m1(axi4_mode, arburst,
                        arlen);
                    rd_left_next = rd_len_next;
                end
            end
            RD_BURST: begin
                if (rd_issue) begin
                    // Only the first address arrives; the rest are ours
                    rd_addr_next = axh_pkg::next_addr(rd_addr_reg,
                        rd_size_reg, rd_burst_reg, rd_len_reg);
                    rd_left_next = rd_left_reg - axh_pkg::LEN_ONE;
                    // Every beat is delivered; the burst never cuts short
                    if (rd_left_reg == '0) begin
                        rd_state_next = RD_IDLE;
                    end
                end
            end
            default: begin
                rd_state_next = RD_IDLE;
            end
        endcase
    end

    // Read state registers; nothing in flight after reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_state_reg <= RD_IDLE;
            rd_addr_reg <= axh_pkg::ADDR_RESET;
            rd_size_reg <= '0;
            rd_burst_reg <= axh_pkg::BURST_FIXED;
            rd_len_reg <= '0;
            rd_left_reg <= '0;
            rd_infl_reg <= 1'b0;
            rd_infl_last_reg <= 1'b0;
        end else begin
            rd_state_reg <= rd_state_next;
            rd_addr_reg <= rd_addr_next;
            rd_size_reg <= rd_size_next;
            rd_burst_reg <= rd_burst_next;
            rd_len_reg <= rd_len_next;
            rd_left_reg <= rd_left_next;
            rd_infl_reg <= rd_infl_next;
            rd_infl_last_reg <= rd_infl_last_next;
        end
    end

    // Write burst sequencing
    always_comb begin
        wr_state_next = wr_state_reg;
        wr_addr_next = wr_addr_reg;
        wr_size_next = wr_size_reg;
        wr_burst_next = wr_burst_reg;
        wr_len_next = wr_len_reg;
        case (wr_state_reg)
            WR_IDLE: begin
                if (aw_hs) begin
                    wr_state_next = WR_DATA;
                    wr_addr_next = awaddr;
                    wr_size_next = awsize;
                    wr_burst_next = awburst;
                    wr_len_next = axh_pkg::beats_m1(axi4_mode, awburst,
                        awlen);
                end
            end
            WR_DATA: begin
                if (w_hs) begin
                    wr_addr_next = axh_pkg::next_addr(wr_addr_reg,
                        wr_size_reg, wr_burst_reg, wr_len_reg);
                    // Response only once the WLAST beat is taken
                    if (wlast) begin
                        wr_state_next = WR_RESP;
                    end
                end
            end
            WR_RESP: begin
                // Response stays up until the master takes it
                if (bready) begin
                    wr_state_next = WR_IDLE;
                end
            end
            default: begin
                wr_state_next = WR_IDLE;
            end
        endcase
    end

    // Write state registers; response low through reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_state_reg <= WR_IDLE;
            wr_addr_reg <= axh_pkg::ADDR_RESET;
            wr_size_reg <= '0;
            wr_burst_reg <= axh_pkg::BURST_FIXED;
            wr_len_reg <= '0;
        end else begin
            wr_state_reg <= wr_state_next;
            wr_addr_reg <= wr_addr_next;
            wr_size_reg <= wr_size_next;
            wr_burst_reg <= wr_burst_next;
            wr_len_reg <= wr_len_next;
        end
    end

    // Backing store
    axh_mem #(
        .WORDS(MEM_WORDS),
        .W(axh_pkg::DATA_W)
    ) u_mem (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(w_hs),
        .wr_idx(word_idx(wr_addr_reg)),
        .wr_be(mem_be),
        .wr_data(wdata),
        .rd_en(rd_issue),
        .rd_idx(word_idx(rd_addr_reg)),
        .rd_data(mem_rdata)
    );

    // Stalled rready backs up here instead of losing a beat
    axh_fifo #(
        .W(BUF_W),
        .DEPTH(BUF_DEPTH)
    ) u_rbuf (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(rd_infl_reg),
        .in_ready(buf_in_ready),
        .in_data({rd_infl_last_reg, mem_rdata}),
        .out_valid(buf_out_valid),
        .out_ready(rready),
        .out_data(buf_out),
        .count(buf_count)
    );

    // Buffer holds its head, so valid and payload stay put
    assign rvalid = buf_out_valid;
    assign rdata = buf_out[axh_pkg::DATA_W-1:0];
    assign rlast = buf_out[axh_pkg::DATA_W];

    // Checking helpers: open read bursts, beats issued
    logic [3:0] chk_open_reg, chk_open_next;
    logic [LW-1:0] chk_beat_reg, chk_beat_next;
    logic chk_aw_reg, chk_aw_next;  // Address taken, no response yet

    // Helper next values
    always_comb begin
        chk_open_next = chk_open_reg + 4'(ar_hs) - 4'(r_hs && rlast);
        chk_beat_next = ar_hs ? '0 :
            (rd_issue ? chk_beat_reg + axh_pkg::LEN_ONE : chk_beat_reg);
        chk_aw_next = aw_hs ? 1'b1 :
            ((bvalid && bready) ? 1'b0 : chk_aw_reg);
    end

    // Helper registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chk_open_reg <= '0;
            chk_beat_reg <= '0;
            chk_aw_reg <= 1'b0;
        end else begin
            chk_open_reg <= chk_open_next;
            chk_beat_reg <= chk_beat_next;
            chk_aw_reg <= chk_aw_next;
        end
    end

    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_r_hold: assert property (rvalid && !rready |=> rvalid &&
        $stable(rdata) && $stable(rlast))
        else $error("read beat dropped or changed before handshake");
    a_b_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped before handshake");
    a_b_done: assert property (bvalid && bready |=> !bvalid)
        else $error("write response kept after handshake");
    a_r_after_ar: assert property (rvalid |-> chk_open_reg != '0)
        else $error("read data with no accepted address");
    a_r_no_wait: assert property (ar_hs && !rvalid |->
        ##[1:3] rvalid)
        else $error("read data did not appear after address");
    a_b_after_last: assert property ($rose(bvalid) |->
        $past(w_hs && wlast))
        else $error("response without a taken WLAST beat");
    a_b_after_aw: assert property (bvalid |-> chk_aw_reg)
        else $error("response before write address taken");
    a_len_short: assert property (ar_hs && (!axi4_mode || arburst !=
        axh_pkg::BURST_INCR) |=> rd_len_reg == ($past(arlen) & 8'h0f))
        else $error("short burst length wrong");
    a_len_long: assert property (ar_hs && axi4_mode &&
        arburst == axh_pkg::BURST_INCR |=> rd_len_reg == $past(arlen))
        else $error("long INCR length wrong");
    a_beat_count: assert property (rd_issue && rd_left_reg == '0 |->
        chk_beat_reg == rd_len_reg ##1 rd_state_reg == RD_IDLE)
        else $error("burst issued wrong number of beats");
    a_fixed_addr: assert property (rd_issue &&
        rd_burst_reg == axh_pkg::BURST_FIXED |=> $stable(rd_addr_reg))
        else $error("fixed burst address moved");
    a_page_kept: assert property (rd_issue && rd_burst_reg !=
        axh_pkg::BURST_FIXED |=> $stable(rd_addr_reg[AW-1:axh_pkg::PAGE_W]))
        else $error("burst address left its 4KB page");
    a_byte_lane: assert property (w_hs && wr_size_reg == '0 |->
        $onehot0(mem_be))
        else $error("byte beat wrote more than one lane");
    a_reset_low: assert property (disable iff (1'b0)
        reset |=> !rvalid && !bvalid)
        else $error("valid high after reset");

    c_read_done: cover property (r_hs && rlast);
    c_write_done: cover property (bvalid && bready);
    c_r_stall: cover property (rvalid && !rready ##1 rvalid && rready);
    c_wrap_read: cover property (rd_issue &&
        rd_burst_reg == axh_pkg::BURST_WRAP);
endmodule

// ===== dv/axh_master.sv
// Master-side model: issues write and read bursts into the slave
`timescale 1ns/1ps
module axh_master (
    input wire logic clk_sys,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic rlast,
    output logic awvalid,
    output logic [31:0] awaddr,
    output logic [7:0] awlen,
    output logic [2:0] awsize,
    output logic [1:0] awburst,
    output logic wvalid,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wlast,
    output logic bready,
    output logic arvalid,
    output logic [31:0] araddr,
    output logic [7:0] arlen,
    output logic [2:0] arsize,
    output logic [1:0] arburst,
    output logic rready
);
    // All valids idle low from time zero, through reset
    initial begin
        {awvalid, awaddr, awlen, awsize, awburst} = '0;
        {wvalid, wdata, wstrb, wlast, bready} = '0;
        {arvalid, araddr, arlen, arsize, arburst, rready} = '0;
    end

    // Address and data raised together, never waiting on a ready
    task automatic wr(input logic [31:0] a, input logic [7:0] l,
            input logic [2:0] s, input logic [1:0] b, input int n,
            input logic [31:0] d[$], input logic [3:0] st[$]);
        fork
            begin
                {awvalid, awaddr, awlen} <= {1'b1, a, l};
                {awsize, awburst} <= {s, b};
                while (awready !== 1'b1) @(negedge clk_sys);
                @(negedge clk_sys);
                {awvalid, awaddr} <= {1'b0, ~a};
            end
            // Every beat is sent, strobes carry what is unwanted
            begin
                // Next beat follows at once; valid never dips between
                for (int i = 0; i < n; i++) begin
                    {wvalid, wdata, wstrb} <= {1'b1, d[i], st[i]};
                    wlast <= (i == n - 1);
                    while (wready !== 1'b1) @(negedge clk_sys);
                    @(negedge clk_sys);
                end
                {wvalid, wdata, wlast} <= {1'b0, ~d[n - 1], 1'b0};
            end
        join
        // Response left waiting two cycles to prove it holds
        repeat (2) @(negedge clk_sys);
        bready <= 1'b1;
        while (bvalid !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        bready <= 1'b0;
    endtask

    // Read burst; stall bits throttle rready, exact length requested
    task automatic rd(input logic [31:0] a, input logic [7:0] l,
            input logic [2:0] s, input logic [1:0] b, input int n,
            input logic [31:0] stall, output logic [31:0] q[$],
            output logic [31:0] lst);
        int c;
        logic r;
        c = 0;
        q = {};
        lst = '0;
        {arvalid, araddr, arlen, arsize, arburst} <= {1'b1, a, l, s, b};
        while (arready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        {arvalid, araddr} <= {1'b0, ~a};
        // Every beat taken, even when stalled a while
        while (q.size() < n) begin
            r = stall[c % 32] || c % 4 == 3;
            rready <= r;
            if (r && rvalid === 1'b1) begin
                q.push_back(rdata);
                lst = {lst[30:0], rlast};
            end
            c++;
            @(negedge clk_sys);
        end
        rready <= 1'b0;
    endtask
endmodule

// ===== dv/axh_slave_tb_top.sv
// Self-checking bench for the memory slave with a byte model
`timescale 1ns/1ps
module axh_slave_tb_top;
    logic clk_sys, reset, axi4_mode, awvalid, awready, wvalid, wready;
    logic wlast, bvalid, bready, arvalid, arready, rvalid, rready, rlast;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [7:0] awlen, arlen;
    logic [2:0] awsize, arsize;
    logic [1:0] awburst, arburst;
    logic [3:0] wstrb;
    logic [7:0] mem_m [0:1023];  // Byte image; 1KB aliases
    logic [31:0] seed = 32'h809d;
    int n_mismatch = 0;
    int check_count = 0;

    axh_slave u_dut (.*);
    axh_master u_mst (.*);

    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Beat count from the length field and mode
    function automatic int beats(logic m, int b, logic [7:0] l);
        return (m && b == 1) ? l + 1 : l[3:0] + 1;
    endfunction

    // Address of beat i, later INCR and WRAP beats aligned
    function automatic int beat_addr(int a, int s, int b, int n, int i);
        int nb, al, wb, tot;
        nb = 1 << s;
        tot = nb * n;
        al = (a / nb) * nb;
        wb = (a / tot) * tot;
        if (i == 0 || b == 0) return a;
        if (b == 2) return wb + (al + i * nb - wb) % tot;
        return al + i * nb;
    endfunction

    // Highest byte lane of a narrow beat
    function automatic int hi_lane(int x, int s);
        return ((x >> s) << s) % 4 + (1 << s) - 1;
    endfunction

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One write burst then the same read, checked per active lane
    task automatic run(logic m, int a, logic [7:0] l, int s, int b,
            logic full);
        logic [31:0] d[$];
        logic [3:0] st[$];
        logic [31:0] q[$];
        logic [31:0] lst, e, k;
        int n, x;
        axi4_mode <= m;
        n = beats(m, b, l);
        for (int i = 0; i < n; i++) begin
            x = beat_addr(a, s, b, n, i);
            d.push_back(rnd());
            st.push_back(full ? 4'hf : 4'(rnd()));
            for (int j = x % 4; j <= hi_lane(x, s); j++) begin
                if (st[i][j]) mem_m[(x & 1020) + j] = d[i][8 * j +: 8];
            end
        end
        u_mst.wr(32'(a), l, 3'(s), 2'(b), n, d, st);
        u_mst.rd(32'(a), l, 3'(s), 2'(b), n, rnd(), q, lst);
        chk("rlast", lst, 32'h1);
        for (int i = 0; i < n; i++) begin
            x = beat_addr(a, s, b, n, i);
            e = '0;
            k = '0;
            for (int j = x % 4; j <= hi_lane(x, s); j++) begin
                k[8 * j +: 8] = 8'hff;
                e[8 * j +: 8] = mem_m[(x & 1020) + j];
            end
            chk("rdata", q[i] & k, e);
        end
    endtask

    // Main sequence: reset, full fill, then random bursts
    initial begin
        int a, s, b;
        logic m;
        logic [7:0] l;
        reset = 1'b1;
        axi4_mode = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("idle", {29'h0, wready, bvalid, rvalid}, 32'h0);
        // Both address channels sit ready while idle, even in reset
        chk("ready", {30'h0, awready, arready}, 32'h3);
        reset <= 1'b0;
        @(negedge clk_sys);
        run(1'b1, 0, 8'hff, 2, 1, 1'b1);
        repeat (40) begin
            b = rnd() % 3;
            s = rnd() % 3;
            m = 1'(rnd());
            // AXI3 lengths carry junk in the top nibble
            l = m ? 8'(rnd() % (b == 1 ? 40 : 16)) : 8'(rnd());
            if (b == 2) l = 8'((2 << (rnd() % 4)) - 1);
            a = rnd() % 1024;
            if (b == 2) a = (a >> s) << s;
            run(m, a, l, s, b, 1'b0);
        end
        close_out();
    end

    // Fill plus forty short bursts need well under 20000 cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        close_out();
    end
endmodule
